// ---- logic/holding_brake_sequencer.sv ----
// Holding-brake sequencer with input terminal function mapping.
////////////////////////////////////////////////////////////////////////////////
//
// Local design decisions: the address-and-strobe port and the register offsets.
module holding_brake_sequencer
   import brake_seq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire brake_seq_pkg::reg_req_s req,
   output logic [15:0] rdata,
   input wire logic [7:0] terminal_in,
   input wire logic [15:0] motor_speed,
   output logic [15:0] func_active,
   output logic brake_interlock_out,
   output logic motor_excite
);
   import brake_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] servo_on_wait_setting, next_servo_on_wait_setting;
   logic [15:0] basic_wait_setting, next_basic_wait_setting;
   logic [15:0] brake_wait_speed, next_brake_wait_speed;
   logic [15:0] brake_wait_time, next_brake_wait_time;
   logic [15:0] input_map_low_group, next_input_map_low_group;
   logic [15:0] input_map_high_group, next_input_map_high_group;
   logic [15:0] map_active_low, next_map_active_low;
   logic [15:0] map_active_high, next_map_active_high;
   logic bk_allocated, next_bk_allocated;
   logic [15:0] next_rdata;

   always_comb begin
      next_servo_on_wait_setting = servo_on_wait_setting;
      next_basic_wait_setting = basic_wait_setting;
      next_brake_wait_speed = brake_wait_speed;
      next_brake_wait_time = brake_wait_time;
      next_input_map_low_group = input_map_low_group;
      next_input_map_high_group = input_map_high_group;
      next_map_active_low = map_active_low;
      next_map_active_high = map_active_high;
      next_bk_allocated = bk_allocated;
      if (req.wr) begin
         case (req.addr)
            ADDR_SERVO_ON_WAIT: next_servo_on_wait_setting = req.wdata;
            ADDR_BASIC_WAIT: next_basic_wait_setting = req.wdata;
            ADDR_BRAKE_SPEED: next_brake_wait_speed = req.wdata;
            ADDR_BRAKE_TIME: next_brake_wait_time = req.wdata;
            ADDR_MAP_LOW: next_input_map_low_group = req.wdata;
            ADDR_MAP_HIGH: next_input_map_high_group = req.wdata;
            ADDR_CONTROL: begin
               next_bk_allocated = req.wdata[CTRL_BK_ALLOC_BIT];
               if (req.wdata[CTRL_RESTART_BIT]) begin
                  // The stored maps only reach the terminals at restart.
                  next_map_active_low = input_map_low_group;
                  next_map_active_high = input_map_high_group;
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   seq_state_e state, next_state;
   logic [15:0] ms_div, next_ms_div;
   logic [15:0] ms_count, next_ms_count;
   logic next_brake_interlock_out, next_motor_excite;
   logic servo_on_sync;
   logic ms_tick;
   logic signed [15:0] on_wait;
   logic [15:0] on_wait_mag;
   logic speed_low, time_up;

   assign on_wait = $signed(servo_on_wait_setting);
   assign on_wait_mag = on_wait[15] ? 16'(-on_wait) : servo_on_wait_setting;
   assign ms_tick = (ms_div == MS_CYCLES_16 - 16'h0001);
   assign speed_low = (motor_speed < brake_wait_speed);
   assign time_up = (ms_count > brake_wait_time);

   always_comb begin
      next_rdata = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            ADDR_SERVO_ON_WAIT: next_rdata = servo_on_wait_setting;
            ADDR_BASIC_WAIT: next_rdata = basic_wait_setting;
            ADDR_BRAKE_SPEED: next_rdata = brake_wait_speed;
            ADDR_BRAKE_TIME: next_rdata = brake_wait_time;
            ADDR_MAP_LOW: next_rdata = input_map_low_group;
            ADDR_MAP_HIGH: next_rdata = input_map_high_group;
            ADDR_CONTROL: next_rdata = {15'h0000, bk_allocated};
            ADDR_STATUS: next_rdata = {12'h000, brake_interlock_out, motor_excite,
                                       servo_on_sync, state == ST_ON};
            ADDR_MAP_ACTIVE_LOW: next_rdata = map_active_low;
            ADDR_MAP_ACTIVE_HIGH: next_rdata = map_active_high;
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   logic [15:0] rdata_q;

   always_comb begin
      next_state = state;
      next_ms_div = ms_tick ? 16'h0000 : ms_div + 16'h0001;
      next_ms_count = ms_count;
      next_brake_interlock_out = brake_interlock_out;
      next_motor_excite = motor_excite;
      case (state)
         ST_OFF: begin
            next_brake_interlock_out = 1'b0;
            next_motor_excite = 1'b0;
            next_ms_count = 16'h0000;
            if (servo_on_sync) begin
               if (!bk_allocated || on_wait_mag == 16'h0000) begin
                  next_brake_interlock_out = bk_allocated;
                  next_motor_excite = 1'b1;
                  next_state = ST_ON;
               end else if (!on_wait[15]) begin
                  next_brake_interlock_out = 1'b1;
                  next_state = ST_ON_WAIT;
               end else begin
                  next_motor_excite = 1'b1;
                  next_state = ST_ON_WAIT;
               end
               next_ms_div = 16'h0000;
            end
         end
         ST_ON_WAIT: begin
            if (!servo_on_sync) begin
               next_motor_excite = 1'b0;
               next_brake_interlock_out = 1'b0;
               next_state = ST_OFF;
            end else begin
               if (ms_tick) next_ms_count = ms_count + 16'h0001;
               if (ms_count >= on_wait_mag) begin
                  next_motor_excite = 1'b1;
                  next_brake_interlock_out = 1'b1;
                  next_ms_count = 16'h0000;
                  next_state = ST_ON;
               end
            end
         end
         ST_ON: begin
            next_ms_count = 16'h0000;
            if (!servo_on_sync) begin
               next_motor_excite = 1'b0;
               next_ms_div = 16'h0000;
               if (!bk_allocated || basic_wait_setting == 16'h0000) begin
                  next_brake_interlock_out = 1'b0;
                  next_state = ST_OFF;
               end else begin
                  next_state = ST_OFF_WAIT;
               end
            end
         end
         ST_OFF_WAIT: begin
            if (servo_on_sync) begin
               next_ms_count = 16'h0000;
               next_motor_excite = 1'b1;
               next_state = ST_ON;
            end else begin
               if (ms_tick) next_ms_count = ms_count + 16'h0001;
               if (speed_low || time_up) begin
                  next_brake_interlock_out = 1'b0;
                  next_state = ST_OFF;
               end
            end
         end
         default: begin
            next_state = ST_OFF;
            next_brake_interlock_out = 1'b0;
            next_motor_excite = 1'b0;
         end
      endcase
      // Dropping the allocation engages the brake at the same edge as the write.
      if (!next_bk_allocated) next_brake_interlock_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] term_stable;
   logic [15:0] next_func_active;

   // The terminals are asynchronous, so each one passes the three-flop filter first.
   pin_filter #(
      .WIDTH(NUM_TERMINALS)
   ) u_pin_filter (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(terminal_in),
      .pin_level(term_stable)
   );

   // Later terminals overwrite earlier ones, so the highest rank wins a clash.
   always_comb begin
      logic [3:0] digit;
      digit = 4'h0;
      next_func_active = 16'h0000;
      for (int t = 0; t < NUM_TERMINALS; t++) begin
         if (t < 4) digit = map_active_low[4*t +: 4];
         else digit = map_active_high[4*(t-4) +: 4];
         next_func_active[digit] = term_stable[t];
      end
   end

   assign servo_on_sync = func_active[FUNC_SERVO_ON];

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         servo_on_wait_setting <= SERVO_ON_WAIT_RESET;
         basic_wait_setting <= BASIC_WAIT_RESET;
         brake_wait_speed <= BRAKE_SPEED_RESET;
         brake_wait_time <= BRAKE_TIME_RESET;
         input_map_low_group <= MAP_LOW_RESET;
         input_map_high_group <= MAP_HIGH_RESET;
         map_active_low <= MAP_LOW_RESET;
         map_active_high <= MAP_HIGH_RESET;
         bk_allocated <= 1'b0;
      end else begin
         servo_on_wait_setting <= next_servo_on_wait_setting;
         basic_wait_setting <= next_basic_wait_setting;
         brake_wait_speed <= next_brake_wait_speed;
         brake_wait_time <= next_brake_wait_time;
         input_map_low_group <= next_input_map_low_group;
         input_map_high_group <= next_input_map_high_group;
         map_active_low <= next_map_active_low;
         map_active_high <= next_map_active_high;
         bk_allocated <= next_bk_allocated;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= next_rdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OFF;
         ms_div <= 16'h0000;
         ms_count <= 16'h0000;
         brake_interlock_out <= 1'b0;
         motor_excite <= 1'b0;
      end else begin
         state <= next_state;
         ms_div <= next_ms_div;
         ms_count <= next_ms_count;
         brake_interlock_out <= next_brake_interlock_out;
         motor_excite <= next_motor_excite;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         func_active <= 16'h0000;
      end else begin
         func_active <= next_func_active;
      end
   end

   assign rdata = rdata_q;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Three-flop pin filter: a level is taken once the second and third stages agree.
module pin_filter #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_level
);
   logic [WIDTH-1:0] stage1, stage2, stage3, next_pin_level;

   always_comb begin
      next_pin_level = pin_level;
      for (int b = 0; b < WIDTH; b++) begin
         if (stage2[b] == stage3[b]) next_pin_level[b] = stage3[b];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         pin_level <= '0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         pin_level <= next_pin_level;
      end
   end
endmodule

// ---- logic/brake_seq_pkg.sv ----
// Package of constants and types for the holding-brake sequencer.
package brake_seq_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [15:0] MS_CYCLES_16 = 16'(MS_CYCLES);
   localparam logic [3:0] ADDR_SERVO_ON_WAIT = 4'h0;
   localparam logic [3:0] ADDR_BASIC_WAIT = 4'h1;
   localparam logic [3:0] ADDR_BRAKE_SPEED = 4'h2;
   localparam logic [3:0] ADDR_BRAKE_TIME = 4'h3;
   localparam logic [3:0] ADDR_MAP_LOW = 4'h4;
   localparam logic [3:0] ADDR_MAP_HIGH = 4'h5;
   localparam logic [3:0] ADDR_CONTROL = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;
   localparam logic [3:0] ADDR_MAP_ACTIVE_LOW = 4'h8;
   localparam logic [3:0] ADDR_MAP_ACTIVE_HIGH = 4'h9;
   localparam int unsigned CTRL_BK_ALLOC_BIT = 0;
   localparam int unsigned CTRL_RESTART_BIT = 1;
   localparam logic [15:0] MAP_LOW_RESET = 16'h3210;
   localparam logic [15:0] MAP_HIGH_RESET = 16'h7654;
   localparam logic [15:0] SERVO_ON_WAIT_RESET = 16'h0000;
   localparam logic [15:0] BASIC_WAIT_RESET = 16'h0000;
   localparam logic [15:0] BRAKE_SPEED_RESET = 16'h0064;
   localparam logic [15:0] BRAKE_TIME_RESET = 16'h01f4;
   localparam int unsigned NUM_TERMINALS = 8;
   localparam int unsigned NUM_FUNCS = 16;
   localparam logic [3:0] FUNC_SERVO_ON = 4'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_ON_WAIT = 4'b0010,
      ST_ON = 4'b0100,
      ST_OFF_WAIT = 4'b1000
   } seq_state_e;
endpackage

// ---- dv/brake_seq_checker.sv ----
// Port assertions for the holding-brake sequencer.
module brake_seq_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire brake_seq_pkg::reg_req_s req,
   input wire logic [15:0] rdata,
   input wire logic [7:0] terminal_in,
   input wire logic [15:0] motor_speed,
   input wire logic [15:0] func_active,
   input wire logic brake_interlock_out,
   input wire logic motor_excite
);
   import brake_seq_pkg::*;
   logic [15:0] sw, thr, tim;
   logic bz, al;
   logic [31:0] cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Shadow settings, and the length of the current coast with the brake released.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sw <= SERVO_ON_WAIT_RESET;
         bz <= (BASIC_WAIT_RESET == 16'h0);
         thr <= BRAKE_SPEED_RESET;
         tim <= BRAKE_TIME_RESET;
         al <= 1'b0;
         cnt <= 32'h0;
      end else begin
         if (req.wr && req.addr == ADDR_SERVO_ON_WAIT) sw <= req.wdata;
         if (req.wr && req.addr == ADDR_BASIC_WAIT) bz <= (req.wdata == 16'h0);
         if (req.wr && req.addr == ADDR_BRAKE_SPEED) thr <= req.wdata;
         if (req.wr && req.addr == ADDR_BRAKE_TIME) tim <= req.wdata;
         if (req.wr && req.addr == ADDR_CONTROL) al <= req.wdata[CTRL_BK_ALLOC_BIT];
         if (brake_interlock_out && !motor_excite && !func_active[0]) cnt <= cnt + 32'h1;
         else cnt <= 32'h0;
      end
   end
   a_read_idle: assert property (!req.rd |=> rdata == 16'h0)
      else $error("read data not idle");
   a_read_speed: assert property (req.rd && req.addr == ADDR_BRAKE_SPEED |=> rdata == thr)
      else $error("speed setting read wrong");
   a_bk_unalloc: assert property (!al |-> !brake_interlock_out)
      else $error("brake released without allocation");
   a_release_first: assert property ($rose(motor_excite) && al && !sw[15]
      && sw != 16'h0 |-> $past(brake_interlock_out))
      else $error("excitation before release");
   a_excite_first: assert property ($rose(brake_interlock_out) && al && sw[15]
      |-> motor_excite && $past(motor_excite))
      else $error("release before excitation");
   a_off_direct: assert property ($fell(func_active[0]) && bz
      |-> ##[1:3] (!brake_interlock_out && !motor_excite))
      else $error("servo off not immediate");
   a_speed_brake: assert property (brake_interlock_out && !motor_excite
      && !func_active[0] && motor_speed < thr |-> ##[1:3] !brake_interlock_out)
      else $error("brake late after slow speed");
   a_time_bound: assert property (cnt <= (32'(tim) + 32'h3) * MS_CYCLES)
      else $error("brake late after wait time");
endmodule
bind holding_brake_sequencer brake_seq_checker u_chk (.mclk(mclk), .rst_n(rst_n),
   .req(req), .rdata(rdata), .terminal_in(terminal_in), .motor_speed(motor_speed),
   .func_active(func_active), .brake_interlock_out(brake_interlock_out),
   .motor_excite(motor_excite));

// ---- dv/brake_partner.sv ----
// Model of the holding brake, the load and the host input terminals.
module brake_partner (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] term_set,
   input wire logic [15:0] spd_set,
   input wire logic brake_interlock_out,
   input wire logic motor_excite,
   output logic [7:0] terminal_in,
   output logic [15:0] motor_speed
);
   timeunit 1ns;
   timeprecision 1ns;
   assign terminal_in = term_set;
   // A driven motor runs at its set speed, a braked one stops and a free one coasts down.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) motor_speed <= 16'h0;
      else if (motor_excite) motor_speed <= spd_set;
      else if (!brake_interlock_out) motor_speed <= 16'h0;
      else if (motor_speed != 16'h0) motor_speed <= motor_speed - 16'h1;
   end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the holding-brake sequencer.
module tb_top;
   import brake_seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   reg_req_s req = '0;
   logic [7:0] term_set = 8'h0;
   logic [15:0] spd_set = 16'h0;
   logic [15:0] rdata, func_active, motor_speed, rd_val;
   logic [7:0] terminal_in;
   logic brake_interlock_out, motor_excite;
   logic [15:0] map_lo, map_hi, act_lo, act_hi;
   logic [15:0] rst_tab [6] = '{SERVO_ON_WAIT_RESET, BASIC_WAIT_RESET,
      BRAKE_SPEED_RESET, BRAKE_TIME_RESET, MAP_LOW_RESET, MAP_HIGH_RESET};
   int err_total = 0;
   int num_checks = 0;
   int n;
   integer seed = 32'h85c6904d;
   holding_brake_sequencer uut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .terminal_in(terminal_in), .motor_speed(motor_speed), .func_active(func_active),
      .brake_interlock_out(brake_interlock_out), .motor_excite(motor_excite));
   brake_partner far_end (.mclk(mclk), .rst_n(rst_n), .term_set(term_set),
      .spd_set(spd_set), .brake_interlock_out(brake_interlock_out),
      .motor_excite(motor_excite), .terminal_in(terminal_in), .motor_speed(motor_speed));
   initial begin
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      req <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 rd_val = rdata;
   endtask
   task automatic sv(input logic v);
      @(posedge mclk);
      term_set <= {7'h0, v};
   endtask
   // Waits on the brake output or on excitation, counting cycles into n.
   task automatic wait_for(input bit on_bk, input logic v);
      n = 0;
      while ((on_bk ? brake_interlock_out : motor_excite) !== v && n < 70000) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("wait_limit", 16'(n < 70000), 16'h1);
   endtask
   function automatic logic [15:0] fmodel(input logic [7:0] t);
      logic [15:0] f;
      logic [31:0] m;
      f = '0;
      m = {act_hi, act_lo};
      for (int i = 0; i < 8; i++) f[m[4*i +: 4]] = t[i];
      return f;
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge mclk);
      err_total++;
      wrap_up;
   end
   initial begin
      {act_hi, act_lo} = {MAP_HIGH_RESET, MAP_LOW_RESET};
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(4'(i));
         chk("reset_value", rd_val, rst_tab[i]);
      end
      rd(4'hf);
      chk("unmapped_read", rd_val, 16'h0);
      for (int k = 0; k < 3; k++) begin
         map_lo = 16'($random(seed));
         map_hi = 16'($random(seed));
         wr(ADDR_MAP_LOW, map_lo);
         wr(ADDR_MAP_HIGH, map_hi);
         for (int j = 0; j < 8; j++) begin
            if (j == 4) begin
               wr(ADDR_CONTROL, 16'h2);
               {act_hi, act_lo} = {map_hi, map_lo};
               rd(ADDR_MAP_ACTIVE_HIGH);
               chk("active_map", rd_val, map_hi);
               rd(ADDR_MAP_ACTIVE_LOW);
               chk("active_map_low", rd_val, map_lo);
            end
            @(posedge mclk);
            term_set <= 8'($random(seed));
            repeat (8) @(posedge mclk);
            #1 chk("func_active", func_active, fmodel(term_set));
         end
      end
      sv(1'b0);
      spd_set <= 16'd200;
      wr(ADDR_MAP_LOW, MAP_LOW_RESET);
      wr(ADDR_MAP_HIGH, MAP_HIGH_RESET);
      wr(ADDR_CONTROL, 16'h3);
      rd(ADDR_CONTROL);
      chk("brake_allocated", rd_val, 16'h1);
      wr(ADDR_SERVO_ON_WAIT, 16'h1);
      sv(1'b1);
      wait_for(1'b1, 1'b1);
      chk("excite_early", 16'(motor_excite), 16'h0);
      wait_for(1'b0, 1'b1);
      chk("excite_delay", 16'(n > MS_CYCLES / 2 && n < 2 * MS_CYCLES), 16'h1);
      rd(ADDR_STATUS);
      chk("status", rd_val, 16'h000f);
      sv(1'b0);
      wait_for(1'b1, 1'b0);
      chk("excite_at_brake", 16'(motor_excite), 16'h0);
      chk("brake_delay", 16'(n < 8), 16'h1);
      wr(ADDR_SERVO_ON_WAIT, 16'h0);
      wr(ADDR_BASIC_WAIT, 16'h1);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            wr(ADDR_BRAKE_SPEED, 16'h0);
            wr(ADDR_BRAKE_TIME, 16'h0);
         end
         sv(1'b1);
         wait_for(1'b0, 1'b1);
         repeat (4) @(posedge mclk);
         sv(1'b0);
         wait_for(1'b0, 1'b0);
         chk("brake_at_off", 16'(brake_interlock_out), 16'h1);
         wait_for(1'b1, 1'b0);
         if (p == 0) begin
            chk("speed_window", 16'(n > 80 && n < 130), 16'h1);
         end else begin
            chk("time_window", 16'(n > MS_CYCLES / 2 && n < 2 * MS_CYCLES), 16'h1);
         end
      end
      wr(ADDR_BASIC_WAIT, 16'h0);
      wr(ADDR_SERVO_ON_WAIT, 16'hffff);
      sv(1'b1);
      wait_for(1'b0, 1'b1);
      repeat (100) @(posedge mclk);
      #1 chk("brake_after_excite", 16'(brake_interlock_out), 16'h0);
      wait_for(1'b1, 1'b1);
      chk("release_delay", 16'(n > MS_CYCLES / 2 && n < 2 * MS_CYCLES), 16'h1);
      sv(1'b0);
      wait_for(1'b0, 1'b0);
      chk("brake_with_off", 16'(brake_interlock_out), 16'h0);
      wrap_up;
   end
endmodule
